// file: hw/wrt_bit_match.v
`include "wrt_consts.vh"
// One entry word against one key word, per bit ternary compare.
module wrt_bit_match #(
    parameter W = `WRT_ENTRY_W
) (
    input wire [W-1:0] key,
    input wire [W-1:0] data,
    input wire [W-1:0] mask,
    output wire hit
);
    wire [W-1:0] bit_ok;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // Data/mask 1/1 never matches, which disables the entry.
            assign bit_ok[i] = (data[i] & mask[i]) ? 1'b0 : (mask[i] | (key[i] == data[i]));
        end
    endgenerate
    assign hit = &bit_ok;
endmodule

// file: hw/wrt_consts.vh
`ifndef WRT_CONSTS_VH
`define WRT_CONSTS_VH
// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define WRT_ADDR_W 10
`define WRT_DEPTH 1024
`define WRT_ENTRY_W 36
`define WRT_ACTION_W 70
`define WRT_CNT_W 1
// ----------------------------------------
// Size encodings, log2 of address span
// ----------------------------------------
`define WRT_SIZE_W 3
`define WRT_ENTRY_SIZE_MAX 3'h4
`define WRT_ACTION_SIZE_MAX 3'h2
// ----------------------------------------
// Reset value and counter set value
// ----------------------------------------
`define WRT_ENA_RST 1'h0
`define WRT_CNT_ONE 1'h1
`endif

// file: hw/wrt_rule_engine.v
// ----------------------------------------
// Contract
// ----------------------------------------
`include "wrt_consts.vh"
module wrt_rule_engine #(
    parameter ADDR_W = `WRT_ADDR_W,
    parameter DEPTH = `WRT_DEPTH,
    parameter EW = `WRT_ENTRY_W,
    parameter AW = `WRT_ACTION_W
) (
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // Rule write port
    input wire WR_EN,
    input wire [ADDR_W-1:0] WR_ADDR,
    input wire [EW-1:0] WR_ENTRY,
    input wire [EW-1:0] WR_MASK,
    input wire [AW-1:0] WR_ACTION,
    input wire WR_CNT,
    // Counter read port
    input wire [ADDR_W-1:0] RD_ADDR,
    output reg RD_CNT,
    // Lookup control
    input wire LOOKUP_ENA,
    // Key port
    input wire KEY_VALID,
    input wire [`WRT_SIZE_W-1:0] KEY_SIZE,
    input wire [EW-1:0] KEY_WORD0,
    input wire [EW*16-1:0] KEY_WIDE,
    input wire [AW-1:0] DEFAULT_ACTION,
    // Result
    output reg RES_VALID,
    output reg RES_HIT,
    output reg RES_DEFAULT,
    output reg [ADDR_W-1:0] RES_ADDR,
    output reg [AW-1:0] RES_ACTION
);
    // ----------------------------------------
    // Rule memory
    // ----------------------------------------
    // Contents are undefined after reset; software must fill every word.
    reg [EW-1:0] mem_entry [0:DEPTH-1];
    reg [EW-1:0] mem_mask [0:DEPTH-1];
    reg [AW-1:0] mem_action [0:DEPTH-1];
    reg mem_cnt [0:DEPTH-1];
    reg lookup_ena;
    reg [ADDR_W-1:0] scan;
    reg [4:0] off;
    reg best_hit;
    reg [ADDR_W-1:0] best_addr;
    reg busy;
    reg [`WRT_SIZE_W-1:0] ksize;
    reg [EW*16-1:0] kwide;
    reg [AW-1:0] kdef;
    wire [4:0] span;
    wire word_hit;
    wire [3:0] key_sel;
    wire [EW-1:0] cur_key;
    wire last_word;
    wire [ADDR_W-1:0] cur_addr;
    localparam SUM_W = ADDR_W + 5;
    localparam [SUM_W-1:0] DEPTH_S = DEPTH;
    wire [SUM_W-1:0] off_sum;
    wire [SUM_W-1:0] next_start;
    wire scan_done;
    reg step_end;
    reg step_take;
    reg next_hit;
    reg [ADDR_W-1:0] next_addr;
    reg [AW-1:0] next_action;
    // Spans larger than supported clamp to sixteen addresses.
    assign span = (ksize > `WRT_ENTRY_SIZE_MAX) ? 5'h10 : (5'h01 << ksize);
    assign key_sel = off[3:0];
    assign cur_key = kwide[key_sel*EW +: EW];
    assign last_word = (off == span - 5'h01);
    // ----------------------------------------
    // Scan address arithmetic
    // ----------------------------------------
    // Sums carry five spare bits, so a small memory scanned with a
    // sixteen-address span neither wraps nor overflows the end compare.
    assign off_sum = {5'h00, scan} + {{ADDR_W{1'b0}}, off};
    assign next_start = {5'h00, scan} + {{ADDR_W{1'b0}}, span};
    assign cur_addr = off_sum[ADDR_W-1:0];
    assign scan_done = (next_start >= DEPTH_S);
    // ----------------------------------------
    // Ternary compare of one word
    // ----------------------------------------
    wrt_bit_match #(.W(EW)) u_match (
        .key(cur_key),
        .data(mem_entry[cur_addr]),
        .mask(mem_mask[cur_addr]),
        .hit(word_hit)
    );
    // ----------------------------------------
    // Scan step decisions
    // ----------------------------------------
    // A start is left on its first mismatching word or after its last word.
    // Only a full match at the first matching start is taken.
    always @* begin
        step_end = 1'b0;
        step_take = 1'b0;
        if (busy) begin
            step_end = !word_hit || last_word;
            step_take = word_hit && last_word && !best_hit;
        end
    end
    // ----------------------------------------
    // Result selection
    // ----------------------------------------
    // An earlier taken start wins over the last one; without any match the
    // action given with the key stands in for the default rule.
    always @* begin
        next_hit = best_hit | (word_hit && last_word);
        next_addr = best_hit ? best_addr : scan;
        next_action = kdef;
        if (best_hit) begin
            next_action = mem_action[best_addr];
        end else if (word_hit && last_word) begin
            next_action = mem_action[scan];
        end
    end
    // ----------------------------------------
    // Memory writes
    // ----------------------------------------
    // Each address is written alone; ordering is the writer's job.
    always @(posedge CLK) begin
        if (WR_EN) begin
            mem_entry[WR_ADDR] <= WR_ENTRY;
            mem_mask[WR_ADDR] <= WR_MASK;
            mem_action[WR_ADDR] <= WR_ACTION;
        end
        if (WR_EN) begin
            mem_cnt[WR_ADDR] <= WR_CNT;
        end else if (step_take) begin
            // Counter at offset zero only, saturating at one.
            mem_cnt[scan] <= `WRT_CNT_ONE;
        end
    end
    // ----------------------------------------
    // Lookup scan
    // ----------------------------------------
    // One word per cycle: slow, but needs one comparator only.
    // Candidate rules sit on span-aligned starts; lowest address wins.
    always @(posedge CLK) begin
        if (!NRST) begin
            lookup_ena <= `WRT_ENA_RST;
            busy <= 1'b0;
            scan <= {ADDR_W{1'b0}};
            off <= 5'h00;
            best_hit <= 1'b0;
            best_addr <= {ADDR_W{1'b0}};
            ksize <= {`WRT_SIZE_W{1'b0}};
            kwide <= {(EW*16){1'b0}};
            kdef <= {AW{1'b0}};
            RES_VALID <= 1'b0;
            RES_HIT <= 1'b0;
            RES_DEFAULT <= 1'b0;
            RES_ADDR <= {ADDR_W{1'b0}};
            RES_ACTION <= {AW{1'b0}};
            RD_CNT <= 1'b0;
        end else begin
            lookup_ena <= LOOKUP_ENA;
            RD_CNT <= mem_cnt[RD_ADDR];
            RES_VALID <= 1'b0;
            if (!busy) begin
                if (KEY_VALID && lookup_ena) begin
                    busy <= 1'b1;
                    scan <= {ADDR_W{1'b0}};
                    off <= 5'h00;
                    best_hit <= 1'b0;
                    ksize <= KEY_SIZE;
                    kwide <= {KEY_WIDE[EW*16-1:EW], KEY_WORD0};
                    kdef <= DEFAULT_ACTION;
                end
            end else if (step_end) begin
                if (step_take) begin
                    best_hit <= 1'b1;
                    best_addr <= scan;
                end
                off <= 5'h00;
                if (scan_done) begin
                    busy <= 1'b0;
                    RES_VALID <= 1'b1;
                    RES_HIT <= next_hit;
                    // No match: the default rule action applies.
                    RES_DEFAULT <= !next_hit;
                    RES_ADDR <= next_addr;
                    RES_ACTION <= next_action;
                end else begin
                    scan <= next_start[ADDR_W-1:0];
                end
            end else begin
                off <= off + 5'h01;
            end
        end
    end
endmodule

// file: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [69:0] DFLT = 70'h15A5A5A5A5A5A5A5A;
    localparam logic [69:0] A1 = 70'h123456789ABCDEF01;
    localparam logic [35:0] KEY = 36'h9ABCDEF01;
    localparam logic [35:0] W0 = 36'h9ABCDEF02;
    localparam logic [35:0] K2 = 36'h5A5A5A5A4;
    logic CLK = 0, NRST = 0, WR_EN = 0, WR_CNT = 0, LOOKUP_ENA = 0, go = 0;
    logic [3:0] WR_ADDR = 0, RD_ADDR = 0, RES_ADDR;
    logic [35:0] WR_ENTRY = 0, WR_MASK = 0, KEY_WORD0, k0 = 0, k1 = 0;
    logic [69:0] WR_ACTION = 0, RES_ACTION;
    logic [575:0] KEY_WIDE;
    logic [2:0] KEY_SIZE, sz = 0;
    logic KEY_VALID, RD_CNT, RES_VALID, RES_HIT, RES_DEFAULT;
    int failures = 0, checked = 0;
    wrt_rule_engine #(.ADDR_W(4), .DEPTH(16)) u_dut (.*, .DEFAULT_ACTION(DFLT));
    wrt_key_src u_src (.clk(CLK), .go(go), .sz(sz), .k0(k0), .k1(k1),
        .kv(KEY_VALID), .ks(KEY_SIZE), .w0(KEY_WORD0), .wide(KEY_WIDE));
    initial forever #10 CLK = ~CLK;
    task close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cmp(input logic [69:0] got, input logic [69:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick; @(posedge CLK); #1; endtask
    task wr(input logic [3:0] a, input logic [35:0] e, input logic [35:0] m, input logic [69:0] act);
        tick;
        {WR_EN, WR_ADDR, WR_ENTRY, WR_MASK, WR_ACTION} = {1'b1, a, e, m, act};
        tick;
        WR_EN = 0;
    endtask
    task look(input logic [2:0] s, input logic [35:0] a, input logic [35:0] b, input logic [3:0] ra);
        int n;
        {sz, k0, k1, RD_ADDR, go} = {s, a, b, ra, 1'b1};
        tick;
        go = 0;
        for (n = 0; n < 80 && RES_VALID !== 1'b1; n++) tick;
        if (n == 80) begin failures++; close_out; end
        tick;
        tick;
    endtask
    task t_init;
        int i;
        for (i = 15; i >= 0; i--) wr(4'(i), '1, '1, '0);
        LOOKUP_ENA = 1;
        tick;
        look(0, KEY, K2, 0);
        cmp(RES_DEFAULT, 1);
        cmp(RES_ACTION, DFLT);
    endtask
    task t_x1;
        // Masked-off bits carry data zero, so they are match-any rather than disabled.
        wr(3, KEY & 36'h000FFFFFF, 36'hFFF000000, A1);
        repeat (2) begin
            look(0, KEY, K2, 3);
            cmp(RES_ADDR, 3);
            cmp(RES_ACTION, A1);
            cmp(RD_CNT, 1);
        end
        look(0, KEY ^ 36'h2, K2, 3);
        cmp(RES_DEFAULT, 1);
    endtask
    task t_x2;
        wr(9, K2, 0, 0);
        wr(8, W0, 0, A1);
        look(1, W0, K2, 8);
        cmp(RES_ADDR, 8);
        cmp(RD_CNT, 1);
        RD_ADDR = 9;
        tick;
        tick;
        cmp(RD_CNT, 0);
        look(1, W0, K2 ^ 36'h10, 8);
        cmp(RES_DEFAULT, 1);
        wr(8, '1, '1, 0);
        look(1, W0, K2, 8);
        cmp(RES_DEFAULT, 1);
    endtask
    initial begin
        repeat (5) @(posedge CLK);
        #1 NRST = 1;
        t_init;
        t_x1;
        t_x2;
        close_out;
    end
endmodule

// file: testbench/wrt_key_src.sv
module wrt_key_src (
    input wire clk, input wire go, input wire [2:0] sz,
    input wire [35:0] k0, input wire [35:0] k1,
    output reg kv, output reg [2:0] ks, output reg [35:0] w0, output reg [575:0] wide
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {kv, ks, w0, wide} = '0;
    // Outside a key the words toggle, so a stale key never passes for a fresh one.
    always @(posedge clk) begin
        kv <= go;
        ks <= go ? sz : ~ks;
        w0 <= go ? k0 : ~w0;
        wide <= go ? {{14{~k1}}, k1, ~k0} : ~wide;
    end
endmodule

// file: testbench/wrt_rule_engine_chk.sv
`include "wrt_consts.vh"
module wrt_chk #(parameter ADDR_W = 10) (
    input wire CLK, input wire NRST, input wire WR_EN, input wire RD_CNT,
    input wire [ADDR_W-1:0] RD_ADDR, input wire [ADDR_W-1:0] RES_ADDR,
    input wire LOOKUP_ENA, input wire KEY_VALID, input wire [`WRT_SIZE_W-1:0] KEY_SIZE,
    input wire RES_VALID, input wire RES_HIT, input wire RES_DEFAULT,
    input wire [`WRT_ACTION_W-1:0] DEFAULT_ACTION, input wire [`WRT_ACTION_W-1:0] RES_ACTION
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    reg ena_q, busy;
    reg [2:0] sz;
    wire acc = KEY_VALID && ena_q && !busy;
    // Mirrors the engine's busy flag but holds it through the result cycle, so a result can be tied to the key that started it.
    always @(posedge CLK) begin
        ena_q <= NRST && LOOKUP_ENA;
        busy <= NRST && (acc || (busy && !RES_VALID));
        if (acc) sz <= KEY_SIZE;
    end
    sequence hit_s; RES_VALID && RES_HIT; endsequence
    sequence rd_s; (RD_ADDR == RES_ADDR && !WR_EN) [*3]; endsequence
    one_pulse_a: assert property (RES_VALID |=> !RES_VALID) else $error("long result");
    one_kind_a: assert property (RES_VALID |-> RES_HIT != RES_DEFAULT) else $error("bad kind");
    from_key_a: assert property (RES_VALID |-> busy) else $error("stray result");
    scan_bound_a: assert property (acc |-> ##[1:40] RES_VALID) else $error("no result");
    dflt_act_a: assert property (RES_VALID && RES_DEFAULT |->
        RES_ACTION == DEFAULT_ACTION) else $error("bad default");
    span_align_a: assert property (hit_s |-> (RES_ADDR & ((1 << sz) - 1)) == 0) else $error("misaligned");
    result_hold_a: assert property (!RES_VALID |=> RES_VALID ||
        $stable({RES_HIT, RES_DEFAULT, RES_ADDR, RES_ACTION})) else $error("result moved");
    hit_count_a: assert property (hit_s ##0 rd_s |-> RD_CNT) else $error("count not set");
endmodule
bind wrt_rule_engine wrt_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
